// file: hw/supply_monitor_pkg.sv
package supply_monitor_pkg;

  // Core clock.
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

  // Post-reset delay, given directly in core clock cycles.
  localparam int DELAY_SHORT_CYC = 256;
  localparam int DELAY_LONG_CYC  = 4096;

  // Least time the reset pin is pulled low once a reset starts.
  localparam int PIN_HOLD_NS  = 20_000;
  localparam int PIN_HOLD_CYC = (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles after release before the reset pin level is trusted again.
  localparam int PIN_SETTLE_CYC = 4;

  // Sequencer counter.
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO         = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE          = 12'h001;
  localparam logic [CNT_W-1:0] DELAY_SHORT_LAST = CNT_W'(DELAY_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] DELAY_LONG_LAST  = CNT_W'(DELAY_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] PIN_HOLD_LAST    = CNT_W'(PIN_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] PIN_SETTLE_LAST  = CNT_W'(PIN_SETTLE_CYC);

  // Register port.
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;
  localparam logic [REG_ADDR_W-1:0] SMCS_ADDR  = 4'h0;
  localparam logic [REG_DATA_W-1:0] SMCS_RESET = 8'h00;
  localparam logic [REG_DATA_W-1:0] READ_IDLE  = 8'h00;

  // Field positions of supply_monitor_ctrl_status.
  localparam int SOURCE_SEL_BIT = 7;
  localparam int IRQ_EN_BIT     = 6;
  localparam int LIVE_FLAG_BIT  = 5;
  localparam int UV_CAUSE_BIT   = 4;
  localparam int WDG_CAUSE_BIT  = 0;
  localparam logic [2:0] RESERVED_READ = 3'h0;

  // Synchroniser lanes.
  localparam int SYNC_W     = 4;
  localparam int SYNC_UV    = 0;
  localparam int SYNC_SUPPLY = 1;
  localparam int SYNC_SENSE = 2;
  localparam int SYNC_PIN   = 3;
  // The reset pin idles high, the comparators idle at "not below".
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'h8;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_ACTIVE,
    SEQ_DELAY
  } seq_state_t;

endpackage

// file: hw/sync_2ff.sv
`timescale 1ns/10ps
module sync_2ff #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// file: hw/supply_integrity_monitor.sv
// Behaviour
// R1 - Hold chip in reset while undervoltage comparator reports low supply.
// R2 - Undervoltage threshold level comes from a non-volatile option, not a register.
// R3 - Drive the reset pin low during an undervoltage reset.
// R4 - Threshold flag and interrupt work only with undervoltage detection enabled.
// R5 - Bit 5 is a read-only live copy of the threshold comparator.
// R6 - Bit 7 selects main supply (0) or external sense pin (1).
// R7 - With bit 6 set, every flag change raises an interrupt request.
// R8 - Entering the service routine clears the pending request automatically.
// R9 - Enabling while flag shows undervoltage raises one request itself.
// R10 - No interrupt for a crossing during the post-reset delay.
// R11 - The request wakes from Wait but not from Halt.
// R12 - Halt freezes the whole control/status register.
// R13 - Interrupt reaches CPU only when enabled and CPU mask cleared.
// R14 - Bit 4 set by undervoltage reset, cleared only by writing zero (the cold reset also clears it).
// R15 - Bit 4 survives later pin or watchdog resets.
// R16 - Bit 0 set by watchdog reset, cleared by zero write or undervoltage.
// R17 - Cause flags encode last reset: pin 00, watchdog 01, undervoltage 1x.
// R18 - Software writes zero to bits 3 to 1.
// R19 - Software ignores watchdog flag when undervoltage detection is disabled.
// R20 - Post-reset delay is 256 or 4096 cycles by option.
// R21 - Comparator outputs pass a two-stage synchroniser first.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module supply_integrity_monitor
  import supply_monitor_pkg::*;
(
  // Clock and cold reset
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // Non-volatile options
  input  wire logic                  undervolt_enable_opt_in,
  input  wire logic [1:0]            undervolt_level_opt_in,
  input  wire logic                  long_delay_opt_in,
  // Analog comparators, asynchronous
  input  wire logic                  undervolt_below_in,
  input  wire logic                  supply_below_in,
  input  wire logic                  sense_pin_below_in,
  // Open-drain reset pin
  input  wire logic                  reset_pin_in,
  output logic                       reset_pin_out,
  output logic                       reset_pin_oe_out,
  // Reset sources and core reset
  input  wire logic                  watchdog_reset_in,
  output logic                       core_reset_out,
  // Analog control
  output logic [1:0]                 undervolt_level_out,
  output logic                       rising_threshold_out,
  output logic                       monitor_source_select_out,
  // CPU state and interrupt
  input  wire logic                  halt_in,
  input  wire logic                  wait_in,
  input  wire logic                  cpu_irq_masked_in,
  input  wire logic                  isr_enter_in,
  output logic                       irq_out,
  output logic                       wake_out,
  // Register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [REG_DATA_W-1:0] reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [REG_DATA_W-1:0]      reg_rdata_out
);

  logic [SYNC_W-1:0]     sync_raw;
  logic [SYNC_W-1:0]     sync_q;
  seq_state_t            state;
  seq_state_t            next_state;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      next_cnt;
  logic                  source_sel;
  logic                  irq_en;
  logic                  live_flag;
  logic                  uv_cause;
  logic                  wdg_cause;
  logic                  pending;
  logic                  next_source_sel;
  logic                  next_irq_en;
  logic                  next_live_flag;
  logic                  next_uv_cause;
  logic                  next_wdg_cause;
  logic                  next_pending;
  logic [REG_DATA_W-1:0] next_rdata;

  // Comparators and the reset pin come from outside the clock domain.
  assign sync_raw = {reset_pin_in, sense_pin_below_in, supply_below_in, undervolt_below_in};

  sync_2ff #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST_VAL)
  ) u_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (sync_raw),
    .sync_out  (sync_q)
  ); // R21

  // Reset sources.
  wire in_run     = (state == SEQ_RUN);
  wire uv_below   = sync_q[SYNC_UV] & undervolt_enable_opt_in; // R1
  // The pin reads back low for a few cycles after our own release, so it is not trusted yet.
  wire pin_trust  = in_run & (cnt == PIN_SETTLE_LAST);
  wire pin_trig   = pin_trust & ~sync_q[SYNC_PIN];
  wire wdg_event  = in_run & watchdog_reset_in;
  wire delay_last_hit = (cnt == (long_delay_opt_in ? DELAY_LONG_LAST : DELAY_SHORT_LAST)); // R20
  wire hold_done  = (cnt >= PIN_HOLD_LAST);

  // Register port decode.
  wire addr_hit   = (reg_addr_in == SMCS_ADDR);
  wire frozen     = halt_in & in_run; // R12
  wire wr_hit     = reg_wr_in & addr_hit & in_run & ~frozen;
  wire rd_hit     = reg_rd_in & addr_hit;

  // Threshold comparator path; the source mux feeds the live flag.
  wire mux_below  = source_sel ? sync_q[SYNC_SENSE] : sync_q[SYNC_SUPPLY]; // R6
  wire live_src   = undervolt_enable_opt_in & mux_below; // R4
  wire flag_change = in_run & ~frozen & (live_src != live_flag);
  wire wr_irq_en  = reg_wdata_in[IRQ_EN_BIT];
  wire arm_set    = wr_hit & wr_irq_en & ~irq_en & live_flag; // R9
  // Events while the chip is in reset or its delay are discarded.
  wire irq_event  = in_run & undervolt_enable_opt_in & ((flag_change & irq_en) | arm_set); // R10

  // Sequencer: pin hold, then the post-reset delay.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      SEQ_RUN: begin
        if (uv_below || pin_trig || wdg_event) begin
          next_state = SEQ_ACTIVE;
          next_cnt   = CNT_ZERO;
        end else if (!pin_trust) begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      SEQ_ACTIVE: begin
        if (!hold_done) begin
          next_cnt = cnt + CNT_ONE;
        end else if (!uv_below) begin // R1
          next_state = SEQ_DELAY;
          next_cnt   = CNT_ZERO;
        end
      end
      SEQ_DELAY: begin
        if (uv_below) begin
          next_state = SEQ_ACTIVE;
          next_cnt   = CNT_ZERO;
        end else if (delay_last_hit) begin // R20
          next_state = SEQ_RUN;
          next_cnt   = CNT_ZERO;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      default: begin
        next_state = SEQ_ACTIVE;
        next_cnt   = CNT_ZERO;
      end
    endcase
  end

  // Control bits return to zero with any reset of the chip.
  assign next_source_sel = !in_run ? 1'b0 : wr_hit ? reg_wdata_in[SOURCE_SEL_BIT] : source_sel;
  assign next_irq_en     = !in_run ? 1'b0 : wr_hit ? wr_irq_en : irq_en;
  assign next_live_flag  = frozen ? live_flag : live_src; // R5

  // A new event in the cycle of entry into the service routine wins.
  assign next_pending = frozen    ? pending :
                        irq_event ? 1'b1 :
                        (!in_run || isr_enter_in) ? 1'b0 : pending; // R8

  // Cause flags: hardware set wins over a software clear.
  assign next_uv_cause  = uv_below | (wr_hit ? (uv_cause & reg_wdata_in[UV_CAUSE_BIT])
                                              : uv_cause); // R14
  wire   wdg_kept       = wr_hit ? (wdg_cause & reg_wdata_in[WDG_CAUSE_BIT]) : wdg_cause;
  // An undervoltage reset in the same cycle outranks a watchdog event, being the real cause.
  assign next_wdg_cause = ~uv_below & (wdg_event | wdg_kept); // R16

  // Bits 3 to 1 always read zero and ignore writes.
  assign next_rdata = rd_hit ? {source_sel, irq_en, live_flag, uv_cause,
                                RESERVED_READ, wdg_cause} : READ_IDLE; // R18

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= SEQ_ACTIVE;
      cnt   <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // The cold reset clears both cause flags; an undervoltage reset clears bit 0, and pin and watchdog resets clear neither.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_cause  <= SMCS_RESET[UV_CAUSE_BIT];
      wdg_cause <= SMCS_RESET[WDG_CAUSE_BIT];
    end else begin
      uv_cause  <= next_uv_cause; // R15
      wdg_cause <= next_wdg_cause; // R17
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      source_sel    <= SMCS_RESET[SOURCE_SEL_BIT];
      irq_en        <= SMCS_RESET[IRQ_EN_BIT];
      live_flag     <= SMCS_RESET[LIVE_FLAG_BIT];
      pending       <= 1'b0;
      reg_rdata_out <= READ_IDLE;
    end else begin
      source_sel    <= next_source_sel;
      irq_en        <= next_irq_en;
      live_flag     <= next_live_flag;
      pending       <= next_pending; // R7
      reg_rdata_out <= next_rdata;
    end
  end

  // Outputs.
  assign reset_pin_out             = 1'b0;
  assign reset_pin_oe_out          = !in_run; // R3
  assign core_reset_out            = !in_run; // R1
  // The analog side uses the rising threshold while the chip is held in reset.
  assign rising_threshold_out      = !in_run;
  assign undervolt_level_out       = undervolt_level_opt_in; // R2
  assign monitor_source_select_out = source_sel;
  assign irq_out  = pending & irq_en & ~cpu_irq_masked_in; // R13
  assign wake_out = pending & irq_en & wait_in & ~halt_in; // R11

  // Checks.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  hold_static_a: assert property ( // R1
    uv_below |=> core_reset_out [*2]
  ) else $error("Core left reset while supply was low.");

  pin_drive_a: assert property ( // R3
    uv_below |=> reset_pin_oe_out && !reset_pin_out
  ) else $error("Reset pin not driven low during undervoltage reset.");

  disabled_flag_a: assert property ( // R4
    (!undervolt_enable_opt_in && !frozen) |=> !live_flag && !pending
  ) else $error("Threshold function active with detection disabled.");

  live_copy_a: assert property ( // R5
    (in_run && !frozen && undervolt_enable_opt_in && !source_sel)
      |=> live_flag == $past(sync_q[SYNC_SUPPLY])
  ) else $error("Live flag does not follow the supply comparator.");

  source_write_a: assert property ( // R6
    wr_hit |=> !in_run || source_sel == $past(reg_wdata_in[SOURCE_SEL_BIT])
  ) else $error("Source select did not take the written value.");

  toggle_irq_a: assert property ( // R7
    (flag_change && irq_en && undervolt_enable_opt_in) |=> pending
  ) else $error("Flag change raised no request.");

  isr_clear_a: assert property ( // R8
    (isr_enter_in && !irq_event && !frozen) |=> !pending
  ) else $error("Service entry did not clear the request.");

  arm_irq_a: assert property ( // R9
    (arm_set && undervolt_enable_opt_in) |=> pending ##1 (pending || $past(isr_enter_in))
  ) else $error("Enabling under low flag raised no request.");

  delay_quiet_a: assert property ( // R10
    !in_run |=> !pending
  ) else $error("Request raised during reset or delay.");

  halt_freeze_a: assert property ( // R12
    frozen |=> $stable({source_sel, irq_en, live_flag, pending})
  ) else $error("Register changed in Halt.");

  irq_gate_a: assert property ( // R13
    irq_out |-> pending && irq_en && !cpu_irq_masked_in
  ) else $error("Interrupt raised without enable or with mask set.");

  wake_gate_a: assert property ( // R11
    wake_out |-> !halt_in && wait_in
  ) else $error("Wake asserted outside Wait.");

  uv_cause_a: assert property ( // R15
    (uv_cause && !wr_hit) |=> uv_cause
  ) else $error("Undervoltage cause lost without a write.");

  wdg_clear_a: assert property ( // R16
    uv_below |=> !wdg_cause
  ) else $error("Watchdog cause not cleared by undervoltage reset.");

  delay_len_a: assert property ( // R20
    (state == SEQ_DELAY && !uv_below && cnt == CNT_ZERO && !long_delay_opt_in)
      |-> ##255 (state == SEQ_DELAY) ##1 in_run || $past(uv_below)
  ) else $error("Short post-reset delay has the wrong length.");

  live_sense_a: assert property ( // R6
    (in_run && !frozen && undervolt_enable_opt_in && source_sel)
      |=> live_flag == $past(sync_q[SYNC_SENSE])
  ) else $error("Live flag does not follow the sense pin comparator.");

  live_readonly_a: assert property ( // R5
    wr_hit |=> live_flag == $past(live_src)
  ) else $error("A register write changed the live flag.");

  rd_live_a: assert property ( // R5
    rd_hit |=> reg_rdata_out[LIVE_FLAG_BIT] == $past(live_flag)
  ) else $error("Read data does not carry the live flag.");

  reserved_read_a: assert property ( // R18
    rd_hit |=> reg_rdata_out[UV_CAUSE_BIT-1:WDG_CAUSE_BIT+1] == RESERVED_READ
  ) else $error("Reserved bits read as nonzero.");

  mask_block_a: assert property ( // R13
    cpu_irq_masked_in |-> !irq_out
  ) else $error("Interrupt raised while the CPU mask was set.");

  wake_stop_a: assert property ( // R11
    halt_in |-> !wake_out
  ) else $error("Wake asserted in Halt.");

  level_pass_a: assert property ( // R2
    undervolt_level_out == undervolt_level_opt_in
  ) else $error("Threshold level does not follow the option.");

  uv_set_a: assert property ( // R14
    uv_below |=> uv_cause
  ) else $error("Undervoltage reset did not set its cause flag.");

  wdg_set_a: assert property ( // R16
    (wdg_event && !uv_below) |=> wdg_cause
  ) else $error("Watchdog reset did not set its cause flag.");

  pin_cause_a: assert property ( // R17
    (pin_trig && !uv_below && !wdg_event && !wr_hit)
      |=> $stable({uv_cause, wdg_cause})
  ) else $error("Pin reset changed a cause flag.");

  irq_seen_c:   cover property (irq_out ##1 isr_enter_in);
  wake_seen_c:  cover property (wake_out);
  wdg_cause_c:  cover property (wdg_event ##1 wdg_cause);
  delay_done_c: cover property (state == SEQ_DELAY ##1 in_run);
  pin_reset_c:  cover property (pin_trig);

endmodule

// file: testbench/cpu_partner.sv
`timescale 1ns/10ps
module cpu_partner (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Interrupt side
  input  wire logic irq_in,
  input  wire logic ack_en_in,
  output logic      isr_enter_out,
  // Open-drain reset pin
  input  wire logic pin_drive_in,
  input  wire logic pin_oe_in,
  input  wire logic ext_low_in,
  output logic      pin_level_out
);
  logic [1:0] lag;

  // The pin has a pull-up, so it reads high unless some party pulls it low.
  assign pin_level_out = ((pin_oe_in && !pin_drive_in) || ext_low_in) ? 1'b0 : 1'b1;

  // The core takes a few cycles to reach the routine, so the reply is never prompt.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lag <= 2'h0;
      isr_enter_out <= 1'b0;
    end else begin
      isr_enter_out <= 1'b0;
      if (irq_in && ack_en_in && !isr_enter_out) begin
        lag <= lag + 2'h1;
        if (lag == 2'h3) begin
          isr_enter_out <= 1'b1;
        end
      end else begin
        lag <= 2'h0;
      end
    end
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import supply_monitor_pkg::*;
  logic       clk_in, arst_n_in, uv_en, long_dly, uv_below, sup_below, sense_below;
  logic       ext_low, wdg, halt, waitm, masked, ack_en, wr, rd, pin_level;
  logic       pin_out, pin_oe, core_rst, rising, src_sel, irq, wake, isr_enter;
  logic [1:0] lvl, lvl_out;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int         errors, checks_done;

  supply_integrity_monitor u_supply_integrity_monitor (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .undervolt_enable_opt_in(uv_en),
    .undervolt_level_opt_in(lvl), .long_delay_opt_in(long_dly),
    .undervolt_below_in(uv_below), .supply_below_in(sup_below),
    .sense_pin_below_in(sense_below), .reset_pin_in(pin_level), .reset_pin_out(pin_out),
    .reset_pin_oe_out(pin_oe), .watchdog_reset_in(wdg), .core_reset_out(core_rst),
    .undervolt_level_out(lvl_out), .rising_threshold_out(rising),
    .monitor_source_select_out(src_sel), .halt_in(halt), .wait_in(waitm),
    .cpu_irq_masked_in(masked), .isr_enter_in(isr_enter), .irq_out(irq), .wake_out(wake),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata));

  cpu_partner u_cpu_partner (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .irq_in(irq), .ack_en_in(ack_en),
    .isr_enter_out(isr_enter), .pin_drive_in(pin_out), .pin_oe_in(pin_oe),
    .ext_low_in(ext_low), .pin_level_out(pin_level));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_range(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask

  task automatic wait_irq(input logic v, input string nm);
    int n;
    n = 0;
    #1;
    while (irq !== v && n < 12) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk(nm, {7'h0, v}, {7'h0, irq});
  endtask

  // Returns the number of cycles the chip stayed in reset.
  task automatic wait_run(output int n);
    n = 0;
    while (core_rst !== 1'b0 && n < 6000) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk("core_reset", 8'h00, {7'h0, core_rst});
  endtask

  task automatic pulse_wdg(output int n);
    @(posedge clk_in);
    wdg <= 1'b1;
    @(posedge clk_in);
    wdg <= 1'b0;
    #1 chk("pin_level", 8'h00, {7'h0, pin_level});
    wait_run(n);
  endtask

  task automatic pulse_pin(output int n);
    @(posedge clk_in);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext_low <= 1'b0;
    #1 chk("pin_reset", 8'h01, {7'h0, core_rst});
    wait_run(n);
  endtask

  task automatic t_cold;
    int n;
    wait_run(n);
    reg_chk(4'h0, SMCS_RESET, "ctrl_status");
    chk("level_out", 8'h02, {6'h0, lvl_out});
    reg_wr(4'h3, 8'hff);
    reg_chk(4'h3, READ_IDLE, "unmapped");
    reg_chk(4'h0, SMCS_RESET, "ctrl_status");
  endtask

  task automatic t_irq_edges;
    ack_en <= 1'b1;
    reg_wr(4'h0, 8'h40);
    wait_irq(1'b0, "irq_idle");
    sup_below <= 1'b1;
    wait_irq(1'b1, "irq_fall");
    reg_chk(4'h0, 8'h60, "ctrl_status");
    wait_irq(1'b0, "irq_ack");
    sup_below <= 1'b0;
    wait_irq(1'b1, "irq_rise");
    wait_irq(1'b0, "irq_ack");
    reg_chk(4'h0, 8'h40, "ctrl_status");
  endtask

  task automatic t_mask_halt;
    ack_en <= 1'b0;
    masked <= 1'b1;
    reg_wr(4'h0, 8'h00);
    sup_below <= 1'b1;
    repeat (6) @(posedge clk_in);
    reg_wr(4'h0, 8'h40);
    repeat (4) @(posedge clk_in);
    #1 chk("irq_masked", 8'h00, {7'h0, irq});
    masked <= 1'b0;
    wait_irq(1'b1, "irq_arm");
    waitm <= 1'b1;
    @(posedge clk_in);
    #1 chk("wake_wait", 8'h01, {7'h0, wake});
    halt <= 1'b1;
    @(posedge clk_in);
    #1 chk("wake_halt", 8'h00, {7'h0, wake});
    reg_wr(4'h0, 8'h80);
    sup_below <= 1'b0;
    repeat (6) @(posedge clk_in);
    reg_chk(4'h0, 8'h60, "frozen");
    chk("irq_frozen", 8'h01, {7'h0, irq});
    halt <= 1'b0;
    waitm <= 1'b0;
    ack_en <= 1'b1;
    repeat (20) @(posedge clk_in);
    reg_wr(4'h0, 8'h00);
    wait_irq(1'b0, "irq_ack");
  endtask

  task automatic t_source;
    reg_wr(4'h0, 8'h80);
    sense_below <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1 chk("source_sel", 8'h01, {7'h0, src_sel});
    reg_chk(4'h0, 8'ha0, "ctrl_status");
    sense_below <= 1'b0;
    reg_wr(4'h0, 8'h00);
    reg_chk(4'h0, 8'h00, "ctrl_status");
  endtask

  task automatic t_watchdog;
    int n;
    pulse_wdg(n);
    chk_range("reset_span", PIN_HOLD_CYC + DELAY_SHORT_CYC - 4,
              PIN_HOLD_CYC + DELAY_SHORT_CYC + 4, n);
    reg_chk(4'h0, 8'h01, "ctrl_status");
    reg_wr(4'h0, 8'h00);
    reg_chk(4'h0, 8'h00, "ctrl_status");
    pulse_pin(n);
    chk_range("reset_span", PIN_HOLD_CYC + DELAY_SHORT_CYC - 4,
              PIN_HOLD_CYC + DELAY_SHORT_CYC + 4, n);
    reg_chk(4'h0, 8'h00, "ctrl_status");
    long_dly <= 1'b1;
    pulse_wdg(n);
    chk_range("reset_span", PIN_HOLD_CYC + DELAY_LONG_CYC - 4,
              PIN_HOLD_CYC + DELAY_LONG_CYC + 4, n);
    long_dly <= 1'b0;
  endtask

  task automatic t_undervolt;
    int n;
    uv_below <= 1'b1;
    sup_below <= 1'b1;
    repeat (1500) @(posedge clk_in);
    #1 chk("core_reset", 8'h01, {7'h0, core_rst});
    chk("pin_level", 8'h00, {7'h0, pin_level});
    uv_below <= 1'b0;
    repeat (10) @(posedge clk_in);
    sup_below <= 1'b0;
    wait_run(n);
    chk("irq_delay", 8'h00, {7'h0, irq});
    reg_chk(4'h0, 8'h10, "ctrl_status");
    reg_wr(4'h0, 8'h50);
    repeat (3) @(posedge clk_in);
    #1 chk("irq_delay_late", 8'h00, {7'h0, irq});
    pulse_pin(n);
    reg_chk(4'h0, 8'h10, "ctrl_status");
    pulse_wdg(n);
    reg_chk(4'h0, 8'h11, "ctrl_status");
    reg_wr(4'h0, 8'h00);
    reg_chk(4'h0, 8'h00, "ctrl_status");
  endtask

  // The watchdog cause is not judged here with detection off.
  task automatic t_disabled;
    uv_en <= 1'b0;
    reg_wr(4'h0, 8'h40);
    sup_below <= 1'b1;
    repeat (6) @(posedge clk_in);
    reg_chk(4'h0, 8'h40, "flag_off");
    chk("irq_off", 8'h00, {7'h0, irq});
    sup_below <= 1'b0;
  endtask

  task automatic complete_run;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {arst_n_in, long_dly, uv_below, sup_below, sense_below, ext_low} = 6'h00;
    {wdg, halt, waitm, masked, ack_en, wr, rd} = 7'h00;
    uv_en = 1'b1;
    lvl = 2'h2;
    addr = 4'h0;
    wdata = 8'h00;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_cold();
    t_irq_edges();
    t_mask_halt();
    t_source();
    t_watchdog();
    t_undervolt();
    t_disabled();
    complete_run();
  end

  // The full sequence needs about 13300 cycles.
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule
